// *** wdt_core.sv ***
// watchdog / interval timer with oscillation stabilization select
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - The period select code 0..7 gives an overflow after 2^12..2^18 or 2^20 clocks in any mode.
// - The period select register resets to zero and reads bits 7..3 as zero.
// - Writing one to mode bit 7 clears the counter and starts it; it stays stopped until then.
// - Once running, a written zero to the run bit is ignored; only reset stops it.
// - Mode bit 4 low gives interval interrupts, pattern 10 a non-maskable request, 11 a reset.
// - Each mode bit once set ignores written zeros until reset.
// - The first overflow after a restart may come up to 2^8 clocks early.
// - The stabilization select resets to four, giving a 2^17-clock wait after reset.
// - Stabilization codes 0..4 select 2^12, 2^14, 2^15, 2^16 or 2^17 clocks; others are banned.
// - Counting goes on in HALT and freezes in STOP; software restarts before STOP.
// - Counting halts while the CPU runs from the subsystem clock.
// - In interval mode every overflow raises the maskable request, gated by the mask; the priority flag only goes out beside it.
// - By default the interval request outranks every other maskable source.
module wdt_core
  import wdt_pkg::*;
#(
  parameter int PRESCALE_LOG2 = WDT_PRESCALE_LOG2
) (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst,
  // register port
  input  wire logic [15:0] reg_addr,
  input  wire logic        reg_wr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  // system state
  input  wire logic        stop_mode,
  input  wire logic        stop_release,
  input  wire logic        sub_clk_sel,
  // interrupt controller flags
  input  wire logic        interval_irq_mask,
  input  wire logic        interval_irq_priority,
  // requests out
  output logic             interval_irq,
  output logic             interval_irq_level,
  output logic [1:0]       interval_irq_rank,
  output logic             nmi_req,
  output logic             reset_req,
  output logic             osc_stable
);

  // upper length follows the nominal 2^8 prescale, so PRESCALE_LOG2 scales all times
  localparam int UPW = WDT_MAX_LOG2 - WDT_PRESCALE_LOG2;

  // =====================================================================
  // register state
  logic [2:0]   period_sel_q;
  logic         run_q;
  logic         watchdog_mode_select_q;
  logic         overflow_action_select_q;
  logic [2:0]   stab_sel_q;
  logic [7:0]   rdata_q;

  // write decode
  logic         wr_period;
  logic         wr_mode;
  logic         wr_stab;
  logic         restart;

  assign wr_period = reg_wr && (reg_addr == WDT_ADDR_PERIOD);
  assign wr_mode   = reg_wr && (reg_addr == WDT_ADDR_MODE);
  assign wr_stab   = reg_wr && (reg_addr == WDT_ADDR_STAB);
  assign restart   = wr_mode && reg_wdata[WDT_RUN_BIT];

  // period select, low three bits only
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      period_sel_q <= WDT_PERIOD_RST;
    end else if (wr_period) begin
      period_sel_q <= reg_wdata[WDT_SEL_W-1:0];
    end
  end

  // run and mode bits only ever go from zero to one
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      run_q                    <= WDT_MODE_BIT_RST;
      watchdog_mode_select_q   <= WDT_MODE_BIT_RST;
      overflow_action_select_q <= WDT_MODE_BIT_RST;
    end else if (wr_mode) begin
      run_q                    <= run_q | reg_wdata[WDT_RUN_BIT];
      watchdog_mode_select_q   <= watchdog_mode_select_q | reg_wdata[WDT_MODE_BIT];
      overflow_action_select_q <= overflow_action_select_q | reg_wdata[WDT_ACT_BIT];
    end
  end

  // stabilization select; software must keep to codes 0..4
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      stab_sel_q <= WDT_STAB_RST;
    end else if (wr_stab) begin
      stab_sel_q <= reg_wdata[WDT_SEL_W-1:0];
    end
  end

  // read data registered one cycle after the strobe; unmapped reads zero
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rdata_q <= WDT_READ_ZERO;
    end else if (reg_rd) begin
      case (reg_addr)
        WDT_ADDR_PERIOD: rdata_q <= {5'h00, period_sel_q};
        WDT_ADDR_MODE:   rdata_q <= {run_q, 2'h0, watchdog_mode_select_q,
                                     overflow_action_select_q, 3'h0};
        WDT_ADDR_STAB:   rdata_q <= {5'h00, stab_sel_q};
        default:         rdata_q <= WDT_READ_ZERO;
      endcase
    end
  end

  assign reg_rdata = rdata_q;

  // =====================================================================
  // counter chain
  logic [PRESCALE_LOG2-1:0] prescale_q;
  logic [UPW-1:0]           upper_q;
  logic [UPW-1:0]           upper_last;
  logic                     clk_ok;
  logic                     tick;
  logic                     overflow;

  // main clock gone to STOP or CPU on subsystem clock freezes everything
  assign clk_ok     = !stop_mode && !sub_clk_sel;
  assign tick       = clk_ok && (&prescale_q);
  assign upper_last = UPW'((1 << (wdt_period_log2(period_sel_q) - WDT_PRESCALE_LOG2)) - 1);
  assign overflow   = run_q && tick && !restart && (upper_q == upper_last);

  // prescaler is never cleared by a restart, hence the early first overflow
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      prescale_q <= '0;
    end else if (clk_ok) begin
      prescale_q <= prescale_q + PRESCALE_LOG2'(1);
    end
  end

  // upper counter: restart wins over a coinciding tick
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      upper_q <= '0;
    end else if (restart) begin
      upper_q <= '0;
    end else if (run_q && tick) begin
      upper_q <= overflow ? '0 : upper_q + UPW'(1);
    end
  end

  // =====================================================================
  // overflow action, one-cycle request pulses
  wdt_action_e action;

  always_comb begin
    if (!watchdog_mode_select_q) begin
      action = WDT_ACT_INTERVAL;
    end else if (overflow_action_select_q) begin
      action = WDT_ACT_RESET;
    end else begin
      action = WDT_ACT_NMI;
    end
  end

  logic       irq_q;
  logic       nmi_q;
  logic       rst_req_q;
  logic       level_q;
  logic [1:0] rank_q;

  // a missed restart in watchdog mode lands here as nmi or reset
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      irq_q     <= 1'b0;
      nmi_q     <= 1'b0;
      rst_req_q <= 1'b0;
    end else begin
      irq_q     <= overflow && (action == WDT_ACT_INTERVAL) && !interval_irq_mask;
      nmi_q     <= overflow && (action == WDT_ACT_NMI);
      rst_req_q <= overflow && (action == WDT_ACT_RESET);
    end
  end

  // priority flag and fixed default rank go along with the request
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      level_q <= 1'b0;
      rank_q  <= 2'h0;
    end else begin
      level_q <= interval_irq_priority;
      rank_q  <= 2'(WDT_DEFAULT_RANK);
    end
  end

  assign interval_irq       = irq_q;
  assign nmi_req            = nmi_q;
  assign reset_req          = rst_req_q;
  assign interval_irq_level = level_q;
  assign interval_irq_rank  = rank_q;

  // =====================================================================
  // stabilization wait after reset and after STOP release
  logic        stab_start_q;
  wdt_stab_if  stab ();

  // start pulse follows reset release; reset value is a constant
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      stab_start_q <= 1'b1;
    end else begin
      stab_start_q <= stop_release;
    end
  end

  assign stab.start = stab_start_q;
  assign stab.sel   = stab_sel_q;
  assign stab.tick  = tick;
  assign osc_stable = stab.stable;

  wdt_stab_timer u_stab (
    .sys_clk (sys_clk),
    .rst     (rst),
    .st      (stab.timer)
  );

  // =====================================================================
  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  property p_run_sticky;
    run_q |=> run_q;
  endproperty
  a_run_sticky: assert property (p_run_sticky) else $error("run bit cleared");

  property p_mode_sticky;
    watchdog_mode_select_q || overflow_action_select_q |=>
      $past(watchdog_mode_select_q) <= watchdog_mode_select_q &&
      $past(overflow_action_select_q) <= overflow_action_select_q;
  endproperty
  a_mode_sticky: assert property (p_mode_sticky) else $error("mode bit cleared");

  property p_restart_clears;
    restart |=> upper_q == '0 ##1 run_q;
  endproperty
  a_restart_clears: assert property (p_restart_clears) else $error("restart missed");

  property p_stopped;
    !run_q |=> upper_q == '0 && !nmi_req && !reset_req;
  endproperty
  a_stopped: assert property (p_stopped) else $error("counting while stopped");

  property p_halt_clk;
    (sub_clk_sel || stop_mode) && !restart |=> $stable(upper_q) && $stable(prescale_q);
  endproperty
  a_halt_clk: assert property (p_halt_clk) else $error("count moved while halted");

  property p_period;
    nmi_req || reset_req || interval_irq |->
      $past(upper_q) == $past(upper_last) && $past(prescale_q) == '1;
  endproperty
  a_period: assert property (p_period) else $error("overflow off period");

  property p_interval_only;
    interval_irq |-> $past(!watchdog_mode_select_q) && $past(!interval_irq_mask);
  endproperty
  a_interval_only: assert property (p_interval_only) else $error("bad interval irq");

  property p_reset_action;
    reset_req |-> $past(watchdog_mode_select_q && overflow_action_select_q) && !nmi_req;
  endproperty
  a_reset_action: assert property (p_reset_action) else $error("bad reset request");

  property p_period_read;
    reg_rd && reg_addr == WDT_ADDR_PERIOD |=> reg_rdata[7:3] == 5'h00;
  endproperty
  a_period_read: assert property (p_period_read) else $error("period upper bits set");

  property p_stab_reset;
    $fell(rst) |-> stab_sel_q == WDT_STAB_RST ##1 !osc_stable;
  endproperty
  a_stab_reset: assert property (p_stab_reset) else $error("bad stab reset");

  c_interval: cover property (interval_irq);
  c_nmi:      cover property (nmi_req);
  c_reset:    cover property (reset_req);
  c_stable:   cover property ($rose(osc_stable));

endmodule
`default_nettype wire

// *** wdt_pkg.sv ***
// shared constants, types and period tables of the watchdog/interval timer
package wdt_pkg;

  // =====================================================================
  // register addresses and reset values
  localparam logic [15:0] WDT_ADDR_PERIOD   = 16'hff42;
  localparam logic [15:0] WDT_ADDR_MODE     = 16'hfff9;
  localparam logic [15:0] WDT_ADDR_STAB     = 16'hfffa;
  localparam logic [2:0]  WDT_PERIOD_RST    = 3'h0;
  localparam logic        WDT_MODE_BIT_RST  = 1'h0;
  localparam logic [2:0]  WDT_STAB_RST      = 3'h4;
  localparam logic [7:0]  WDT_READ_ZERO     = 8'h00;

  // =====================================================================
  // field positions
  localparam int WDT_SEL_W    = 3;
  localparam int WDT_RUN_BIT  = 7;
  localparam int WDT_MODE_BIT = 4;
  localparam int WDT_ACT_BIT  = 3;

  // =====================================================================
  // timing: all figures but the default rank are powers of two of main clock cycles
  localparam int WDT_PRESCALE_LOG2 = 8;
  localparam int WDT_MAX_LOG2      = 20;
  localparam int WDT_STAB_MAX_LOG2 = 17;
  localparam int WDT_DEFAULT_RANK  = 0;

  typedef enum logic [1:0] {WDT_ACT_INTERVAL, WDT_ACT_NMI, WDT_ACT_RESET} wdt_action_e;

  // overflow period exponent per select code
  function automatic int wdt_period_log2(input logic [2:0] sel);
    case (sel)
      3'h7:    return 20;
      default: return 12 + int'(sel);
    endcase
  endfunction

  // stabilization exponent; prohibited codes fall back to the longest wait
  function automatic int wdt_stab_log2(input logic [2:0] sel);
    case (sel)
      3'h0:    return 12;
      3'h1:    return 14;
      3'h2:    return 15;
      3'h3:    return 16;
      default: return 17;
    endcase
  endfunction

endpackage

// *** wdt_stab_if.sv ***
// carrier between the watchdog core and its stabilization timer
`timescale 1ns/1ps
`default_nettype none
interface wdt_stab_if;
  logic       start;
  logic [2:0] sel;
  logic       tick;
  logic       stable;
  modport ctrl  (output start, output sel, output tick, input stable);
  modport timer (input start, input sel, input tick, output stable);
endinterface
`default_nettype wire

// *** wdt_stab_timer.sv ***
// oscillation stabilization wait timer counting prescaler ticks
`timescale 1ns/1ps
`default_nettype none
module wdt_stab_timer
  import wdt_pkg::*;
(
  // clock and reset
  input  wire logic   sys_clk,
  input  wire logic   rst,
  // link to the core
  wdt_stab_if.timer   st
);

  // tick count is fixed by the nominal 2^8 prescale; a short prescaler only speeds it up
  localparam int CW = WDT_STAB_MAX_LOG2 - WDT_PRESCALE_LOG2 + 1;

  typedef enum logic {WDT_ST_IDLE, WDT_ST_WAIT} wdt_st_e;

  wdt_st_e        state_q;
  logic [CW-1:0]  cnt_q;
  logic [CW-1:0]  last_tick;
  logic           stable_q;

  // last tick index of the selected wait
  assign last_tick = CW'((1 << (wdt_stab_log2(st.sel) - WDT_PRESCALE_LOG2)) - 1);

  // =====================================================================
  // wait sequence; a new start always restarts the wait
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_q  <= WDT_ST_IDLE;
      cnt_q    <= '0;
      stable_q <= 1'b0;
    end else if (st.start) begin
      state_q  <= WDT_ST_WAIT;
      cnt_q    <= '0;
      stable_q <= 1'b0;
    end else begin
      case (state_q)
        WDT_ST_WAIT: begin
          if (st.tick) begin
            if (cnt_q == last_tick) begin
              state_q  <= WDT_ST_IDLE;
              stable_q <= 1'b1;
            end else begin
              cnt_q <= cnt_q + CW'(1);
            end
          end
        end
        default: state_q <= WDT_ST_IDLE;
      endcase
    end
  end

  assign st.stable = stable_q;

  // =====================================================================
  // checks
  property p_stab_done;
    @(posedge sys_clk) disable iff (rst)
      $rose(stable_q) |-> $past(cnt_q) == $past(last_tick) && $past(st.tick);
  endproperty
  a_stab_done: assert property (p_stab_done) else $error("stable without full wait");

endmodule
`default_nettype wire

// *** wdt_cpu_model.sv ***
// cpu side partner: interrupt flags and request counters
`timescale 1ns/1ps
`default_nettype none
module wdt_cpu_model (
  // clock
  input  wire logic sys_clk,
  // requests from the timer
  input  wire logic irq,
  input  wire logic nmi,
  input  wire logic rreq,
  // interrupt controller flags
  output logic      mask,
  output logic      prio
);
  // ==========================================================
  // counters, read by the bench
  int cyc   = 0;
  int n_irq = 0;
  int n_nmi = 0;
  int n_rst = 0;
  int t_irq = 0;
  // flags belong to the controller; the bench flips them
  initial begin
    mask = 1'b0;
    prio = 1'b0;
  end
  task automatic set_flags(input logic m, input logic p);
    mask = m;
    prio = p;
  endtask
  // requests are one-cycle pulses, so one count per edge
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (irq === 1'b1) begin
      n_irq <= n_irq + 1;
      t_irq <= cyc;
    end
    if (nmi === 1'b1) n_nmi <= n_nmi + 1;
    if (rreq === 1'b1) n_rst <= n_rst + 1;
  end
endmodule
`default_nettype wire

// *** wdt_core_tb.sv ***
// self-checking bench of the watchdog/interval timer core
`timescale 1ns/1ps
`default_nettype none
module wdt_core_tb;
  import wdt_pkg::*;
  // ==========================================================
  // shortened prescaler: every count is 2^(8-P) smaller
  localparam int P  = 2;
  localparam int SH = 8 - P;
  logic        sys_clk = 1'b0;
  logic        rst     = 1'b1;
  logic [15:0] addr    = 16'h0000;
  logic        wr      = 1'b0;
  logic        rd      = 1'b0;
  logic [7:0]  wdata   = 8'h00;
  logic        stop    = 1'b0;
  logic        srel    = 1'b0;
  logic        subc    = 1'b0;
  logic [7:0]  rdata;
  logic        mask, prio, irq, lvl, nmi, rreq, ostb;
  logic [1:0]  rank;
  int          n_errors = 0;
  int          checks   = 0;
  int          tick     = 0;
  int          rel      = 0;
  int          stab_e[5] = '{12, 14, 15, 16, 17};
  // ==========================================================
  // design and partner
  wdt_core #(.PRESCALE_LOG2(P)) dut_u (.sys_clk(sys_clk), .rst(rst),
    .reg_addr(addr), .reg_wr(wr), .reg_wdata(wdata), .reg_rd(rd), .reg_rdata(rdata),
    .stop_mode(stop), .stop_release(srel), .sub_clk_sel(subc),
    .interval_irq_mask(mask), .interval_irq_priority(prio), .interval_irq(irq),
    .interval_irq_level(lvl), .interval_irq_rank(rank), .nmi_req(nmi),
    .reset_req(rreq), .osc_stable(ostb));
  wdt_cpu_model cpu (.sys_clk(sys_clk), .irq(irq), .nmi(nmi), .rreq(rreq),
    .mask(mask), .prio(prio));
  // clock, and a ceiling well above the 57000 cycles the run needs
  initial forever #5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    tick <= tick + 1;
    if (tick == 80000) begin
      n_errors++;
      end_of_test;
    end
  end
  // ==========================================================
  // shared tasks
  task automatic end_of_test;
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  // inputs always change 1 ns after the edge
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic wreg(input logic [15:0] a, input logic [7:0] d);
    cyc(1);
    addr = a;
    wdata = d;
    wr = 1'b1;
    cyc(1);
    wr = 1'b0;
  endtask
  // one spare cycle before sampling: read data holds until the next read
  task automatic rchk(input logic [15:0] a, input logic [7:0] exp, input string what);
    cyc(1);
    addr = a;
    rd = 1'b1;
    cyc(1);
    rd = 1'b0;
    cyc(1);
    chk(what, rdata, exp);
  endtask
  function automatic int cnt(input int w);
    return w == 0 ? cpu.n_irq : (w == 1 ? cpu.n_nmi : cpu.n_rst);
  endfunction
  // cycles until request w shows up, -1 if it does not within lim cycles
  task automatic wait_ev(input int w, input int lim, output int dt);
    int c0;
    int n0;
    c0 = tick;
    n0 = cnt(w);
    dt = -1;
    for (int i = 0; i < lim && dt < 0; i++) begin
      cyc(1);
      if (cnt(w) != n0) dt = tick - c0;
    end
  endtask
  task automatic osc_chk(input int t0, input int m);
    for (int i = 0; i < m + 8 && ostb !== 1'b1; i++) cyc(1);
    chk("osc wait", tick - t0 >= m - 4 && tick - t0 <= m + 4, 1'b1);
  endtask
  // ==========================================================
  // scenarios
  task automatic t_reset_vals;
    chk("osc early", ostb, 1'b0);
    rchk(WDT_ADDR_PERIOD, 8'h00, "period rst");
    rchk(WDT_ADDR_MODE, 8'h00, "mode rst");
    rchk(WDT_ADDR_STAB, 8'h04, "stab rst");
    rchk(16'hff43, 8'h00, "unmapped");
    osc_chk(rel, 1 << (17 - SH));
    chk("idle", cpu.n_irq + cpu.n_nmi + cpu.n_rst, 0);
    wreg(WDT_ADDR_PERIOD, 8'hff);
    rchk(WDT_ADDR_PERIOD, 8'h07, "period bits");
  endtask
  task automatic t_stab(input logic [2:0] s, input int e);
    int t0;
    wreg(WDT_ADDR_STAB, {5'h1f, s});
    rchk(WDT_ADDR_STAB, {5'h00, s}, "stab bits");
    srel = 1'b1;
    cyc(1);
    srel = 1'b0;
    t0 = tick;
    cyc(3);
    chk("osc low", ostb, 1'b0);
    osc_chk(t0, 1 << (e - SH));
  endtask
  task automatic t_period(input logic [2:0] k);
    int n;
    int dt;
    int t1;
    n = 1 << ((k == 3'h7 ? 20 : 12 + int'(k)) - SH);
    wreg(WDT_ADDR_PERIOD, {5'h00, k});
    wreg(WDT_ADDR_MODE, 8'h80);
    wait_ev(0, n + 8, dt);
    chk("first overflow", dt >= n - 4 && dt <= n + 3, 1'b1);
    t1 = cpu.t_irq;
    wait_ev(0, n + 8, dt);
    chk("period", cpu.t_irq - t1, n);
  endtask
  task automatic t_mask;
    int dt;
    cpu.set_flags(1'b1, 1'b1);
    wreg(WDT_ADDR_PERIOD, 8'h00);
    wreg(WDT_ADDR_MODE, 8'h80);
    chk("level", lvl, 1'b1);
    chk("rank", rank, 2'h0);
    wait_ev(0, 200, dt);
    chk("masked", dt, -1);
    cpu.set_flags(1'b0, 1'b0);
    wreg(WDT_ADDR_MODE, 8'h00);
    chk("level off", lvl, 1'b0);
    rchk(WDT_ADDR_MODE, 8'h80, "run sticky");
    wait_ev(0, 80, dt);
    chk("still running", dt > 0, 1'b1);
  endtask
  // freeze 100 cycles, 20 cycles after a restart with a 64-cycle period
  task automatic t_freeze(input bit sub);
    int dt;
    int n0;
    wreg(WDT_ADDR_MODE, 8'h80);
    n0 = cpu.n_irq;
    cyc(20);
    stop = !sub;
    subc = sub;
    cyc(100);
    stop = 1'b0;
    subc = 1'b0;
    chk("frozen", cpu.n_irq, n0);
    wait_ev(0, 80, dt);
    chk("resumed", dt >= 36 && dt <= 47, 1'b1);
  endtask
  task automatic t_watchdog(input logic act);
    int dt;
    int w;
    int n0;
    int n1;
    w = act ? 2 : 1;
    wreg(WDT_ADDR_MODE, {4'h9, act, 3'h0});
    rchk(WDT_ADDR_MODE, {4'h9, act, 3'h0}, "wd mode");
    wreg(WDT_ADDR_MODE, 8'h00);
    rchk(WDT_ADDR_MODE, {4'h9, act, 3'h0}, "mode sticky");
    // software restarts well inside the period
    repeat (6) begin
      wait_ev(w, 40, dt);
      chk("restarted", dt, -1);
      wreg(WDT_ADDR_MODE, 8'h90);
    end
    n0 = cpu.n_irq;
    n1 = cnt(3 - w);
    wait_ev(w, 80, dt);
    chk("bite", dt > 0, 1'b1);
    chk("no irq", cpu.n_irq, n0);
    chk("other action", cnt(3 - w), n1);
  endtask
  task automatic do_reset;
    rst = 1'b1;
    cyc(20);
    rst = 1'b0;
    rel = tick;
  endtask
  // ==========================================================
  // main sequence
  initial begin
    #1;
    do_reset;
    t_reset_vals;
    for (int s = 0; s < 5; s++) t_stab(3'(s), stab_e[s]);
    for (int k = 0; k < 8; k++) t_period(3'(k));
    t_mask;
    t_freeze(1'b0);
    t_freeze(1'b1);
    t_watchdog(1'b0);
    do_reset;
    rchk(WDT_ADDR_MODE, 8'h00, "mode cleared");
    t_watchdog(1'b1);
    do_reset;
    end_of_test;
  end
endmodule
`default_nettype wire
